// ### core/general_pin_config_and_monitor.sv
// Purpose: general pin function select, output levels and level monitor registers
// Assumes: register port is a simple synchronous strobe interface from the control port
// Notes: other pin configuration fields are inputs from elsewhere in the device
// How it works
// R1 - function field is bits 7:4; code 0 leaves second input pin unattached
// R2 - code 7 makes the pin a power-down input for all channels
// R3 - code 8 makes the pin switch microphone bias on and off
// R4 - code 9 makes the pin a general input readable in the monitor
// R5 - code 10 takes the master clock from the pin
// R6 - code 11 makes the pin the daisy-chain serial data input
// R7 - code 14 carries pulse-density data for channels five and six
// R8 - code 15 carries pulse-density data for channels seven and eight
// R9 - software must not write codes 1 to 6, 12 or 13
// R10 - output register bit 7 sets first bidirectional pin output level
// R11 - output register bit 6 sets second bidirectional pin output level
// R12 - output register bit 5 sets third bidirectional pin output level
// R13 - monitor bit 7 returns first bidirectional pin input level
// R14 - monitor bit 6 returns second bidirectional pin input level
// R15 - monitor bit 5 returns third bidirectional pin input level
// R16 - monitor bit 4 returns first input-only pin level when general input
// R17 - monitor bit 3 returns second input-only pin level when general input
// R18 - reserved bits read zero; software writes only zero there
// R19 - bidirectional pin drives its output level only with function code 1
// R20 - monitored levels pass a two-flop synchroniser before the monitor
`timescale 1ns/10ps
`default_nettype none
`include "pin_cfg_consts.svh"
module general_pin_config_and_monitor (
  input wire logic clk_sys, // register clock, 10 MHz
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, registered
  output logic reg_hit, // address decodes to this block
  input wire pin_cfg_pkg::func_code_t bidir_one_func, // function field of first bidir pin
  input wire pin_cfg_pkg::func_code_t bidir_two_func, // function field of second bidir pin
  input wire pin_cfg_pkg::func_code_t bidir_three_func, // function field of third bidir pin
  input wire pin_cfg_pkg::func_code_t input_one_func, // function field of first input pin
  input wire logic bidir_pin_one_i, // first bidir pin level in
  output logic bidir_pin_one_o, // first bidir pin level out
  output logic bidir_pin_one_oe, // first bidir pin drive enable
  input wire logic bidir_pin_two_i, // second bidir pin level in
  output logic bidir_pin_two_o, // second bidir pin level out
  output logic bidir_pin_two_oe, // second bidir pin drive enable
  input wire logic bidir_pin_three_i, // third bidir pin level in
  output logic bidir_pin_three_o, // third bidir pin level out
  output logic bidir_pin_three_oe, // third bidir pin drive enable
  input wire logic input_only_pin_one, // first input-only pin
  input wire logic input_only_pin_two, // second input-only pin
  output logic all_channel_power_down, // power down request to all converters
  output logic mic_bias_switch, // microphone bias enable from pin
  output logic mic_bias_ctrl_sel, // pin owns microphone bias control
  output logic mclk_from_pin_sel, // master clock taken from pin
  output logic chain_serial_data_in, // daisy-chain serial data
  output logic chain_data_sel, // chain input routed from pin
  output logic pulse_density_data_a, // pdm data for channels 5 and 6
  output logic pulse_density_data_b, // pdm data for channels 7 and 8
  output logic pdm_a_sel, // pdm a routed from pin
  output logic pdm_b_sel, // pdm b routed from pin
  output logic mclk_pin // raw pin to the clock tree
);
  import pin_cfg_pkg::*;

  logic [7:0] in2_func_reg;
  logic [7:0] out_levels_reg;
  logic [7:0] level_mon;
  logic [4:0] sync_levels;
  logic [4:0] raw_levels;
  func_code_t in2_code;
  in2_role_e in2_role;
  logic [3:0] in1_code_q;

  // true when a bidir function field selects plain output
  function automatic logic is_gpo(input func_code_t c);
    return c == `FUNC_GPO;
  endfunction

  // true when a function field selects plain input
  function automatic logic is_gpi(input func_code_t c);
    return c == `FUNC_GPI;
  endfunction

  assign in2_code = in2_func_reg[`IN2_FUNC_MSB:`IN2_FUNC_LSB]; // R1

  in2_role_decode u_decode (
    .code(in2_code),
    .role(in2_role)
  );

  // register writes; reserved bits are masked so they always hold zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in2_func_reg <= `RST_IN2_FUNC;
      out_levels_reg <= `RST_OUT_LEVELS;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `ADDR_IN2_FUNC)
        in2_func_reg <= reg_wdata & `IN2_FUNC_MASK; // R18
      if (reg_addr == `ADDR_OUT_LEVELS)
        out_levels_reg <= reg_wdata & `OUT_LEVELS_MASK; // R18
    end
  end

  // second input pin level is used raw by the data and clock functions; no extra delay on data paths
  assign raw_levels = {bidir_pin_one_i, bidir_pin_two_i, bidir_pin_three_i,
                       input_only_pin_one, input_only_pin_two};

  level_sync #(.W(5)) u_sync ( // R20
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .d(raw_levels),
    .q(sync_levels)
  );

  // function field of first input pin taken as a register stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in1_code_q <= `FUNC_DISABLED;
    end else if (clk_en) begin
      in1_code_q <= input_one_func;
    end
  end

  // monitor: each bit shows its pin only while that pin is a general input
  always_comb begin
    level_mon = `RST_LEVEL_MON;
    level_mon[`MON_B1_POS] = sync_levels[4] & is_gpi(bidir_one_func); // R13
    level_mon[`MON_B2_POS] = sync_levels[3] & is_gpi(bidir_two_func); // R14
    level_mon[`MON_B3_POS] = sync_levels[2] & is_gpi(bidir_three_func); // R15
    level_mon[`MON_I1_POS] = sync_levels[1] & is_gpi(in1_code_q); // R16
    level_mon[`MON_I2_POS] = sync_levels[0] & (in2_role == ROLE_GPI); // R4 R17
  end

  // read mux; unmapped offsets in this block read zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        `ADDR_IN2_FUNC: reg_rdata <= in2_func_reg & `IN2_FUNC_MASK; // R18
        `ADDR_OUT_LEVELS: reg_rdata <= out_levels_reg & `OUT_LEVELS_MASK; // R18
        `ADDR_LEVEL_MON: reg_rdata <= level_mon & `MON_MASK; // R18
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign reg_hit = (reg_addr == `ADDR_IN2_FUNC) || (reg_addr == `ADDR_OUT_LEVELS) ||
                   (reg_addr == `ADDR_LEVEL_MON);

  // bidir drivers; a pin is released unless its field selects plain output
  assign bidir_pin_one_o = out_levels_reg[`OUT_B1_POS]; // R10
  assign bidir_pin_two_o = out_levels_reg[`OUT_B2_POS]; // R11
  assign bidir_pin_three_o = out_levels_reg[`OUT_B3_POS]; // R12
  assign bidir_pin_one_oe = is_gpo(bidir_one_func); // R19
  assign bidir_pin_two_oe = is_gpo(bidir_two_func); // R19
  assign bidir_pin_three_oe = is_gpo(bidir_three_func); // R19

  // control functions use the synchronised level to avoid glitchy power events
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      all_channel_power_down <= 1'b0;
      mic_bias_switch <= 1'b0;
    end else if (clk_en) begin
      all_channel_power_down <= (in2_role == ROLE_PDOWN) & sync_levels[0]; // R2
      mic_bias_switch <= (in2_role == ROLE_BIAS) & sync_levels[0]; // R3
    end
  end
  assign mic_bias_ctrl_sel = (in2_role == ROLE_BIAS); // R3

  // data and clock functions route the raw pin; sampling would alias fast signals
  assign mclk_from_pin_sel = (in2_role == ROLE_MCLK); // R5
  assign mclk_pin = mclk_from_pin_sel & input_only_pin_two; // R5
  assign chain_data_sel = (in2_role == ROLE_CHAIN); // R6
  assign chain_serial_data_in = chain_data_sel & input_only_pin_two; // R6
  assign pdm_a_sel = (in2_code == `FUNC_PDM_A); // R7
  assign pdm_b_sel = (in2_code == `FUNC_PDM_B); // R8
  assign pulse_density_data_a = pdm_a_sel & input_only_pin_two; // R7
  assign pulse_density_data_b = pdm_b_sel & input_only_pin_two; // R8

  // assertions
  reserved_cfg_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
    in2_func_reg[3:0] == 4'h0 && out_levels_reg[4:0] == 5'h00)
    else $error("reserved bits hold nonzero value");
  disabled_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    in2_code == `FUNC_DISABLED |-> !mclk_from_pin_sel && !chain_data_sel &&
    !pdm_a_sel && !pdm_b_sel && !mic_bias_ctrl_sel)
    else $error("disabled pin has a function");
  pdown_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    clk_en && in2_code == `FUNC_POWER_DOWN && $stable(in2_code) ##1 clk_en |->
    all_channel_power_down == $past(sync_levels[0]))
    else $error("power down does not follow pin");
  bias_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    clk_en && in2_code != `FUNC_MIC_BIAS |=> !mic_bias_switch)
    else $error("bias driven without bias function");
  gpi_mon_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
    in2_code != `FUNC_GPI |-> !level_mon[`MON_I2_POS])
    else $error("second input monitor shows while not general input");
  clk_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    mclk_from_pin_sel |-> mclk_pin == input_only_pin_two)
    else $error("clock not routed from pin");
  out_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    clk_en && reg_wr && reg_addr == `ADDR_OUT_LEVELS |=>
    bidir_pin_one_o == $past(reg_wdata[7]) && bidir_pin_three_o == $past(reg_wdata[5]))
    else $error("output level not taken from write");
  drive_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
    bidir_pin_two_oe |-> bidir_two_func == `FUNC_GPO)
    else $error("pin driven without output function");
  mon_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    clk_en ##1 clk_en ##1 (clk_en && is_gpi(bidir_one_func)) |->
    level_mon[`MON_B1_POS] == $past(bidir_pin_one_i, 2))
    else $error("monitor not two stages behind pin");
  pdm_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
    pdm_b_sel |-> pulse_density_data_b == input_only_pin_two && !pdm_a_sel)
    else $error("pdm b not routed");
  gpi_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    in2_role == ROLE_GPI && level_mon[`MON_I2_POS]);
  gpo_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    bidir_pin_one_oe && bidir_pin_one_o);
  pdown_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    all_channel_power_down);
  bias_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    mic_bias_switch);
  pdm_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    pulse_density_data_b);

  // register side: writes land next cycle, nothing moves otherwise
  func_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R1
    clk_en && reg_wr && reg_addr == `ADDR_IN2_FUNC |=> in2_code == $past(reg_wdata[7:4]))
    else $error("function field not taken from write");

  out_two_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    clk_en && reg_wr && reg_addr == `ADDR_OUT_LEVELS |=>
    bidir_pin_two_o == $past(reg_wdata[6]))
    else $error("second output level not taken from write");

  out_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    !(clk_en && reg_wr && reg_addr == `ADDR_OUT_LEVELS) |=> $stable(out_levels_reg))
    else $error("output levels changed without write");

  freeze_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !clk_en |=> $stable(in2_func_reg) && $stable(out_levels_reg) && $stable(reg_rdata))
    else $error("state moved while clock enable low");

  rd_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(clk_en && reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without read");

  rdata_rsv_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
    clk_en && reg_rd |=> reg_rdata[2:0] == 3'h0)
    else $error("reserved read bits nonzero");

  mon_rsv_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
    level_mon[2:0] == 3'h0)
    else $error("reserved monitor bits nonzero");

  // monitor bits stay quiet unless their pin is a general input
  mon_b1_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    !is_gpi(bidir_one_func) |-> !level_mon[`MON_B1_POS])
    else $error("first bidir monitor shows while not input");

  mon_b2_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
    !is_gpi(bidir_two_func) |-> !level_mon[`MON_B2_POS])
    else $error("second bidir monitor shows while not input");

  mon_b3_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    !is_gpi(bidir_three_func) |-> !level_mon[`MON_B3_POS])
    else $error("third bidir monitor shows while not input");

  mon_i1_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    !is_gpi(in1_code_q) |-> !level_mon[`MON_I1_POS])
    else $error("first input monitor shows while not input");

  // monitor bits follow their pin two enabled edges late
  mon_b2_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R14
    clk_en ##1 clk_en ##1 (clk_en && is_gpi(bidir_two_func)) |->
    level_mon[`MON_B2_POS] == $past(bidir_pin_two_i, 2))
    else $error("second bidir monitor not two stages behind pin");

  mon_b3_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    clk_en ##1 clk_en ##1 (clk_en && is_gpi(bidir_three_func)) |->
    level_mon[`MON_B3_POS] == $past(bidir_pin_three_i, 2))
    else $error("third bidir monitor not two stages behind pin");

  mon_i1_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
    clk_en ##1 clk_en ##1 (clk_en && is_gpi(in1_code_q)) |->
    level_mon[`MON_I1_POS] == $past(input_only_pin_one, 2))
    else $error("first input monitor not two stages behind pin");

  mon_i2_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
    clk_en ##1 clk_en ##1 (clk_en && in2_role == ROLE_GPI) |->
    level_mon[`MON_I2_POS] == $past(input_only_pin_two, 2))
    else $error("second input monitor not two stages behind pin");

  gpi_role_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    in2_role == ROLE_GPI |-> level_mon[`MON_I2_POS] == sync_levels[0])
    else $error("general input level not in monitor");

  // drive enables follow the output function only
  drive_one_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
    bidir_pin_one_oe == is_gpo(bidir_one_func))
    else $error("first pin drive enable wrong");

  drive_three_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R19
    bidir_pin_three_oe == is_gpo(bidir_three_func))
    else $error("third pin drive enable wrong");

  // control functions of the second input pin
  pdown_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    clk_en && in2_role != ROLE_PDOWN |=> !all_channel_power_down)
    else $error("power down without power down function");

  bias_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    clk_en && in2_role == ROLE_BIAS |=> mic_bias_switch == $past(sync_levels[0]))
    else $error("bias does not follow pin");

  // raw routes are gated off when not selected
  clk_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
    !mclk_from_pin_sel |-> !mclk_pin)
    else $error("clock leaks without clock function");

  chain_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    chain_data_sel |-> chain_serial_data_in == input_only_pin_two)
    else $error("chain data not routed");

  chain_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    !chain_data_sel |-> !chain_serial_data_in)
    else $error("chain data leaks without chain function");

  pdm_a_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    pdm_a_sel |-> pulse_density_data_a == input_only_pin_two && !pdm_b_sel)
    else $error("pdm a not routed");

  pdm_a_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    !pdm_a_sel |-> !pulse_density_data_a)
    else $error("pdm a leaks without its function");
endmodule
`default_nettype wire

// ### core/in2_role_decode.sv
// Purpose: decodes the second input pin function code into a one-hot role
// Assumes: reserved codes map to off
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "pin_cfg_consts.svh"
module in2_role_decode (
  input wire pin_cfg_pkg::func_code_t code, // function field
  output pin_cfg_pkg::in2_role_e role // decoded role
);
  import pin_cfg_pkg::*;
  // reserved codes behave as disabled so nothing is attached to the pin
  always_comb begin
    unique case (code)
      `FUNC_POWER_DOWN: role = ROLE_PDOWN;
      `FUNC_MIC_BIAS: role = ROLE_BIAS;
      `FUNC_GPI: role = ROLE_GPI;
      `FUNC_MCLK: role = ROLE_MCLK;
      `FUNC_CHAIN_DIN: role = ROLE_CHAIN;
      `FUNC_PDM_A, `FUNC_PDM_B: role = ROLE_PDM;
      default: role = ROLE_OFF;
    endcase
  end
endmodule
`default_nettype wire

// ### core/level_sync.sv
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: one clock, clock enable freezes both stages
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module level_sync #(parameter int W = 5) (
  input wire logic clk_sys, // register clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_reg;
  // two flops, metastability settles in the first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### core/pin_cfg_consts.svh
// Purpose: offsets, field positions, reset values and codes of the pin registers
// Assumes: 8-bit register space reached through the device control port
// Notes: definitions only
`ifndef PIN_CFG_CONSTS_SVH
`define PIN_CFG_CONSTS_SVH
`define ADDR_IN2_FUNC 8'h25
`define ADDR_OUT_LEVELS 8'h26
`define ADDR_LEVEL_MON 8'h27
`define RST_IN2_FUNC 8'h00
`define RST_OUT_LEVELS 8'h00
`define RST_LEVEL_MON 8'h00
`define IN2_FUNC_MSB 7
`define IN2_FUNC_LSB 4
`define OUT_B1_POS 7
`define OUT_B2_POS 6
`define OUT_B3_POS 5
`define MON_B1_POS 7
`define MON_B2_POS 6
`define MON_B3_POS 5
`define MON_I1_POS 4
`define MON_I2_POS 3
`define OUT_LEVELS_MASK 8'he0
`define IN2_FUNC_MASK 8'hf0
`define MON_MASK 8'hf8
`define FUNC_DISABLED 4'h0
`define FUNC_GPO 4'h1
`define FUNC_POWER_DOWN 4'h7
`define FUNC_MIC_BIAS 4'h8
`define FUNC_GPI 4'h9
`define FUNC_MCLK 4'ha
`define FUNC_CHAIN_DIN 4'hb
`define FUNC_PDM_A 4'he
`define FUNC_PDM_B 4'hf
`endif

// ### core/pin_cfg_pkg.sv
// Purpose: shared types of the general pin block
// Assumes: codes live in pin_cfg_consts.svh
// Notes: role type is one-hot, one bit per role of the second input pin; both pdm codes share the pdm bit
package pin_cfg_pkg;
  typedef logic [3:0] func_code_t;
  typedef enum logic [6:0] {
    ROLE_OFF = 7'h01,
    ROLE_PDOWN = 7'h02,
    ROLE_BIAS = 7'h04,
    ROLE_GPI = 7'h08,
    ROLE_MCLK = 7'h10,
    ROLE_CHAIN = 7'h20,
    ROLE_PDM = 7'h40
  } in2_role_e;
endpackage

// ### test/pin_partner.sv
// Purpose: outside logic wired to the general pins
// Assumes: the outside drives a bidir pin only while the device releases it
// Notes: a driven pin reads back the device's own level
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input wire logic [4:0] ext_level, // levels applied from outside
  input wire logic [2:0] dev_o, // device output levels
  input wire logic [2:0] dev_oe, // device drive enables
  output logic [2:0] bidir_i, // resolved bidir pin levels
  output logic in_one, // first input-only pin
  output logic in_two // second input-only pin
);
  // device wins where it drives, so no contention is modelled
  assign bidir_i = (dev_oe & dev_o) | (~dev_oe & ext_level[4:2]);
  assign in_one = ext_level[1];
  assign in_two = ext_level[0];
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: register and pin checks of the general pin block
// Assumes: strobe bus, read data sampled one edge after the read edge
// Notes: inputs change 10 ns after a rising edge, except 11 ns at the start of the code loop
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pin_cfg_pkg::*;
  logic clk_sys = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_hit;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  func_code_t bf = 4'h1, i1f = 4'h0;
  logic [4:0] ext = 5'h00;
  logic [2:0] po, poe, pi;
  logic in1, in2, pd, bias, bsel, msel, csel, asel, bsl, cdat, pda, pdb, mpin;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic [3:0] codes [10] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'he, 4'hf, 4'h8, 4'h7};
  logic [3:0] c;
  general_pin_config_and_monitor general_pin_config_and_monitor_i (.clk_sys(clk_sys),
    .resetn(resetn), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bidir_one_func(bf),
    .bidir_two_func(bf), .bidir_three_func(bf), .input_one_func(i1f),
    .bidir_pin_one_i(pi[2]), .bidir_pin_one_o(po[2]), .bidir_pin_one_oe(poe[2]),
    .bidir_pin_two_i(pi[1]), .bidir_pin_two_o(po[1]), .bidir_pin_two_oe(poe[1]),
    .bidir_pin_three_i(pi[0]), .bidir_pin_three_o(po[0]), .bidir_pin_three_oe(poe[0]),
    .input_only_pin_one(in1), .input_only_pin_two(in2), .all_channel_power_down(pd),
    .mic_bias_switch(bias), .mic_bias_ctrl_sel(bsel), .mclk_from_pin_sel(msel),
    .chain_serial_data_in(cdat), .chain_data_sel(csel), .pulse_density_data_a(pda),
    .pulse_density_data_b(pdb), .pdm_a_sel(asel), .pdm_b_sel(bsl), .mclk_pin(mpin));
  pin_partner pin_partner_i (.ext_level(ext), .dev_o(po), .dev_oe(poe), .bidir_i(pi),
    .in_one(in1), .in_two(in2));
  // free-running clock, 100 ns period
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // every bus task ends 10 ns after an edge and starts there, except the first code write at 11 ns
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #10 reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk_sys);
    #10 reg_rd = 0;
    @(posedge clk_sys);
    #10 chk(what, exp, reg_rdata);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard, the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #10 resetn = 1;
    rd(8'h25, 8'h00, "func reset");
    rd(8'h26, 8'h00, "out reset");
    rd(8'h27, 8'h00, "mon reset");
    // output levels, drive enables, readback, frozen write and unmapped offset
    wr(8'h26, 8'ha0);
    chk("pin out", 8'h05, {5'h0, po});
    chk("pin oe", 8'h07, {5'h0, poe});
    wr(8'h26, 8'he0);
    rd(8'h26, 8'he0, "out readback");
    clk_en = 0;
    wr(8'h26, 8'h00);
    clk_en = 1;
    rd(8'h26, 8'he0, "frozen write");
    wr(8'h28, 8'hff);
    chk("hit", 8'h00, {7'h0, reg_hit});
    rd(8'h28, 8'h00, "unmapped");
    bf = 4'h0;
    #1 chk("pin oe off", 8'h00, {5'h0, poe});
    // every defined function code of the second input pin with the pin held high
    ext = 5'h01;
    for (int k = 0; k < 10; k++) begin
      c = codes[k];
      wr(8'h25, {c, 4'h0});
      repeat (4) @(posedge clk_sys);
      #10 chk("sel", {c == 8, c == 10, c == 11, c == 14, c == 15, c == 7, c == 8, 1'b0},
        {bsel, msel, csel, asel, bsl, pd, bias, 1'b0});
      chk("data", {4'h0, c == 10, c == 11, c == 14, c == 15}, {4'h0, mpin, cdat, pda, pdb});
      rd(8'h25, {c, 4'h0}, "func readback");
      rd(8'h27, {4'h0, c == 9, 3'h0}, "mon by code");
    end
    // monitor with all pins as general inputs
    bf = 4'h9;
    i1f = 4'h9;
    wr(8'h25, 8'h90);
    ext = 5'h16;
    repeat (3) @(posedge clk_sys);
    #10 rd(8'h27, 8'hb0, "mon a");
    ext = 5'h09;
    repeat (3) @(posedge clk_sys);
    #10 rd(8'h27, 8'h48, "mon b");
    summarize();
  end
endmodule
`default_nettype wire
